// ### design/dtc_checker.sv
// Purpose: DDR4 command spacing checker with per-target issue permits
// Assumes: scheduler on the same clock; cmd_i.vld marks an issued command
// Notes:   permits are registered and are valid for the current cycle

`timescale 1ns/1ns

module dtc_checker
    import dtc_pkg::*;
(
    input  wire logic            clk_i,
    input  wire logic            reset_n_i,
    input  wire dtc_cmd_t        cmd_i,
    input  wire logic            wr_last_i,
    input  wire logic [1:0]      wr_last_bg_i,
    input  wire logic [RA_W-1:0] reg_addr_i,
    input  wire logic [RD_W-1:0] reg_wdata_i,
    input  wire logic            reg_wr_i,
    input  wire logic            reg_rd_i,
    output logic [RD_W-1:0]      reg_rdata_o,
    output logic [15:0]          act_ok_o,
    output logic [3:0]           rd_ok_o,
    output logic [3:0]           wr_ok_o,
    output logic [3:0]           ref_ok_o,
    output logic [3:0]           ref_req_o
);

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    function automatic logic [9:0] sat_inc(input logic [9:0] c);
        return (c == CNT_MAX) ? c : 10'(c + 10'h001);
    endfunction : sat_inc

    function automatic logic ge(input logic [9:0] c, input logic [9:0] l);
        return c >= l;
    endfunction : ge

    // ----------------------------------------------------------------
    // register file
    // ----------------------------------------------------------------
    logic [9:0]  tim_ff [16];
    logic [15:0] cfg_ff;
    logic        viol_ff;
    logic [15:0] rdata_ff;

    wire logic        m3        = cfg_ff[CFG_3DS];
    wire logic        refen     = cfg_ff[CFG_REFEN];
    wire logic        wr_cfg    = reg_wr_i && (reg_addr_i == IX_CFG);
    wire logic        wr_tim    = reg_wr_i && (reg_addr_i >= IX_RRD_S)
                                  && (reg_addr_i <= IX_REFI);
    wire logic        clr_viol  = reg_wr_i && (reg_addr_i == IX_STATUS)
                                  && reg_wdata_i[ST_VIOL];

    // ----------------------------------------------------------------
    // command decode; without 3DS every command maps to logical rank 0
    // ----------------------------------------------------------------
    wire logic [1:0]  lr     = m3 ? cmd_i.lr : 2'h0;
    wire logic [1:0]  bg     = cmd_i.bg;
    wire logic [3:0]  ix     = {lr, bg};
    wire logic        is_act = cmd_i.vld && (cmd_i.kind == CK_ACT);
    wire logic        is_rd  = cmd_i.vld && (cmd_i.kind == CK_RD);
    wire logic        is_wr  = cmd_i.vld && (cmd_i.kind == CK_WR);
    wire logic        is_ref = cmd_i.vld && (cmd_i.kind == CK_REF);
    wire logic        is_cas = is_rd || is_wr;

    // ----------------------------------------------------------------
    // elapsed counters, all but refi_ff start saturated so nothing waits at reset but rank 1-3 activates, held one cycle by act_ok_o; refi_ff starts at zero
    // ----------------------------------------------------------------
    logic [9:0] act_bg_ff [16];
    logic [9:0] act_lr_ff [4];
    logic [9:0] act_any_ff;
    logic [1:0] act_last_ff;
    logic [9:0] faw_ff    [16];
    logic [9:0] xfaw_ff   [4];
    logic [9:0] cas_bg_ff [4];
    logic [9:0] cas_any_ff;
    logic [9:0] wtr_ff    [4];
    logic [9:0] ref_lr_ff [4];
    logic [9:0] ref_any_ff;
    logic [1:0] ref_last_ff;
    logic [9:0] refi_ff   [4];
    logic [3:0] req_ff;

    logic [9:0] nxt_act_bg [16];
    logic [9:0] nxt_act_lr [4];
    logic [9:0] nxt_act_any;
    logic [9:0] nxt_faw    [16];
    logic [9:0] nxt_xfaw   [4];
    logic [9:0] nxt_cas_bg [4];
    logic [9:0] nxt_cas_any;
    logic [9:0] nxt_wtr    [4];
    logic [9:0] nxt_ref_lr [4];
    logic [9:0] nxt_ref_any;
    logic [9:0] nxt_refi   [4];
    logic [3:0] nxt_req;
    logic [1:0] nxt_act_last;
    logic [1:0] nxt_ref_last;

    // a counter reads N in the Nth cycle after its event, so a limit of N
    // allows the next command exactly N cycles later
    always_comb begin
        for (int i = 0; i < 16; i++) begin
            nxt_act_bg[i] = (is_act && ix == 4'(i)) ? 10'h001
                                                    : sat_inc(act_bg_ff[i]);
            nxt_faw[i] = sat_inc(faw_ff[i]);
        end
        for (int l = 0; l < 4; l++) begin
            nxt_act_lr[l] = (is_act && lr == 2'(l)) ? 10'h001
                                                    : sat_inc(act_lr_ff[l]);
            if (is_act && lr == 2'(l)) begin
                nxt_faw[l*4] = 10'h001;
                for (int k = 1; k < 4; k++) begin
                    nxt_faw[l*4+k] = sat_inc(faw_ff[l*4+k-1]);
                end
            end
            nxt_ref_lr[l] = (is_ref && lr == 2'(l)) ? 10'h001
                                                    : sat_inc(ref_lr_ff[l]);
            nxt_refi[l] = (is_ref && lr == 2'(l)) ? 10'h000
                                                  : sat_inc(refi_ff[l]);
            // reaching the interval sets, a refresh to the rank clears
            nxt_req[l] = refen && (m3 || l == 0)
                         && ge(nxt_refi[l], tim_ff[IX_REFI]);
        end
        for (int k = 0; k < 4; k++) begin
            nxt_xfaw[k] = (is_act) ? ((k == 0) ? 10'h001
                                               : sat_inc(xfaw_ff[k-1]))
                                   : sat_inc(xfaw_ff[k]);
            nxt_cas_bg[k] = (is_cas && bg == 2'(k)) ? 10'h001
                                                    : sat_inc(cas_bg_ff[k]);
            nxt_wtr[k] = (wr_last_i && wr_last_bg_i == 2'(k)) ? 10'h001
                                                : sat_inc(wtr_ff[k]);
        end
        nxt_act_any  = is_act ? 10'h001 : sat_inc(act_any_ff);
        nxt_cas_any  = is_cas ? 10'h001 : sat_inc(cas_any_ff);
        nxt_ref_any  = is_ref ? 10'h001 : sat_inc(ref_any_ff);
        nxt_act_last = is_act ? lr : act_last_ff;
        nxt_ref_last = is_ref ? lr : ref_last_ff;
    end

    // ----------------------------------------------------------------
    // permits, computed from next state so they hold in the next cycle
    // ----------------------------------------------------------------
    logic [15:0] nxt_act_ok;
    logic [3:0]  nxt_rd_ok;
    logic [3:0]  nxt_wr_ok;
    logic [3:0]  nxt_ref_ok;

    always_comb begin
        for (int i = 0; i < 16; i++) begin
            automatic int l = i / 4;
            nxt_act_ok[i] =
                ge(nxt_act_bg[i], tim_ff[IX_RRD_L])
                && ge(nxt_act_lr[l], tim_ff[IX_RRD_S])
                && (!m3 || nxt_act_last == 2'(l)
                    || ge(nxt_act_any, tim_ff[IX_RRD_DLR]))
                && ge(nxt_faw[l*4+3], tim_ff[IX_FAW])
                && (!m3 || ge(nxt_xfaw[3], tim_ff[IX_FAW_DLR]))
                && ge(nxt_ref_lr[l], tim_ff[IX_RFC])
                && (!m3 || nxt_ref_last == 2'(l)
                    || ge(nxt_ref_any, tim_ff[IX_RFC_DLR]))
                && !nxt_req[l]
                && (m3 || l == 0);
        end
        for (int g = 0; g < 4; g++) begin
            nxt_wr_ok[g] = ge(nxt_cas_any, tim_ff[IX_CCD_S])
                           && ge(nxt_cas_bg[g], tim_ff[IX_CCD_L]);
            nxt_rd_ok[g] = nxt_wr_ok[g];
            for (int w = 0; w < 4; w++) begin
                if (!ge(nxt_wtr[w], (w == g) ? tim_ff[IX_WTR_L]
                                             : tim_ff[IX_WTR_S])) begin
                    nxt_rd_ok[g] = 1'b0;
                end
            end
            // no second refresh to a rank while its last one is running
            nxt_ref_ok[g] = ge(nxt_ref_lr[g], tim_ff[IX_RFC])
                            && (m3 || g == 0);
        end
    end

    // a command issued against a low permit is a scheduler fault
    wire logic bad_cmd = (is_act && !act_ok_o[ix])
                         || (is_rd && !rd_ok_o[bg])
                         || (is_wr && !wr_ok_o[bg])
                         || (is_ref && !ref_ok_o[lr]);

    wire logic [15:0] rd_mux =
        (reg_addr_i == IX_CFG)    ? cfg_ff :
        (reg_addr_i == IX_STATUS) ? {8'h00, req_ff, 3'h0, viol_ff} :
        wr_tim                    ? 16'h0000 :
        (reg_addr_i <= IX_REFI)   ? {6'h00, tim_ff[reg_addr_i]} :
                                    16'h0000;

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            for (int i = 0; i < 16; i++) begin
                act_bg_ff[i] <= CNT_MAX;
                faw_ff[i]    <= CNT_MAX;
            end
            for (int k = 0; k < 4; k++) begin
                act_lr_ff[k] <= CNT_MAX;
                xfaw_ff[k]   <= CNT_MAX;
                cas_bg_ff[k] <= CNT_MAX;
                wtr_ff[k]    <= CNT_MAX;
                ref_lr_ff[k] <= CNT_MAX;
                refi_ff[k]   <= 10'h000;
            end
            tim_ff[IX_CFG]     <= 10'h000;
            tim_ff[IX_RRD_S]   <= 10'(RRD_S_CYC);
            tim_ff[IX_RRD_L]   <= 10'(RRD_L_CYC);
            tim_ff[IX_RRD_DLR] <= 10'(RRD_DLR_CYC);
            tim_ff[IX_FAW]     <= FAW_RST;
            tim_ff[IX_FAW_DLR] <= 10'(FAW_DLR_CYC);
            tim_ff[IX_CCD_S]   <= 10'(CCD_S_CYC);
            tim_ff[IX_CCD_L]   <= 10'(CCD_L_CYC);
            tim_ff[IX_WTR_S]   <= 10'(WTR_S_CYC);
            tim_ff[IX_WTR_L]   <= 10'(WTR_L_CYC);
            tim_ff[IX_RFC]     <= RFC_RST;
            tim_ff[IX_RFC_DLR] <= RFC_DLR_RST;
            tim_ff[IX_REFI]    <= REFI_RST;
            tim_ff[IX_STATUS]  <= 10'h000;
            tim_ff[14]         <= 10'h000;
            tim_ff[15]         <= 10'h000;
            cfg_ff      <= CFG_RST;
            viol_ff     <= 1'b0;
            rdata_ff    <= 16'h0000;
            act_any_ff  <= CNT_MAX;
            cas_any_ff  <= CNT_MAX;
            ref_any_ff  <= CNT_MAX;
            act_last_ff <= 2'h0;
            ref_last_ff <= 2'h0;
            req_ff      <= 4'h0;
            act_ok_o    <= 16'h000F;
            rd_ok_o     <= 4'hF;
            wr_ok_o     <= 4'hF;
            ref_ok_o    <= 4'hF;
        end else begin
            act_bg_ff   <= nxt_act_bg;
            faw_ff      <= nxt_faw;
            act_lr_ff   <= nxt_act_lr;
            xfaw_ff     <= nxt_xfaw;
            cas_bg_ff   <= nxt_cas_bg;
            wtr_ff      <= nxt_wtr;
            ref_lr_ff   <= nxt_ref_lr;
            refi_ff     <= nxt_refi;
            act_any_ff  <= nxt_act_any;
            cas_any_ff  <= nxt_cas_any;
            ref_any_ff  <= nxt_ref_any;
            act_last_ff <= nxt_act_last;
            ref_last_ff <= nxt_ref_last;
            req_ff      <= nxt_req;
            act_ok_o    <= nxt_act_ok;
            rd_ok_o     <= nxt_rd_ok;
            wr_ok_o     <= nxt_wr_ok;
            ref_ok_o    <= nxt_ref_ok;
            if (wr_tim) begin
                tim_ff[reg_addr_i] <= reg_wdata_i[9:0];
            end
            if (wr_cfg) begin
                cfg_ff <= {14'h0000, reg_wdata_i[1:0]};
            end
            // a fault in the clearing cycle still sets the flag
            viol_ff  <= bad_cmd || (viol_ff && !clr_viol);
            rdata_ff <= reg_rd_i ? rd_mux : 16'h0000;
        end
    end

    assign reg_rdata_o = rdata_ff;
    assign ref_req_o   = req_ff;

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!reset_n_i);

    rrd_long_a: assert property (
        is_act && tim_ff[IX_RRD_L] > 10'h001 |=> !act_ok_o[$past(ix)])
        else $error("same bank group activate permitted too soon");

    rrd_short_a: assert property (
        is_act && tim_ff[IX_RRD_S] > 10'h002
        |=> ##1 act_ok_o[{$past(lr, 2), 2'h0} +: 4] == 4'h0)
        else $error("activate permitted inside short interval");

    rrd_dlr_a: assert property (
        is_act && m3 && tim_ff[IX_RRD_DLR] > 10'h001
        && tim_ff[IX_RRD_S] > 10'h001 |=> act_ok_o == 16'h0000)
        else $error("cross rank activate permitted too soon");

    ccd_gap_a: assert property (
        is_cas && tim_ff[IX_CCD_S] > 10'h001
        |=> rd_ok_o == 4'h0 && wr_ok_o == 4'h0)
        else $error("column command permitted inside tCCD_S");

    wtr_gap_a: assert property (
        wr_last_i && tim_ff[IX_WTR_S] > 10'h001
        && tim_ff[IX_WTR_L] > 10'h001 |=> rd_ok_o == 4'h0)
        else $error("read permitted inside write to read interval");

    rfc_wait_a: assert property (
        is_ref && tim_ff[IX_RFC] > 10'h002
        |=> ##1 act_ok_o[{$past(lr, 2), 2'h0} +: 4] == 4'h0)
        else $error("activate permitted during refresh cycle");

    rfc_dlr_a: assert property (
        is_ref && m3 && tim_ff[IX_RFC_DLR] > 10'h001
        && tim_ff[IX_RFC] > 10'h001 |=> act_ok_o == 16'h0000)
        else $error("activate permitted too soon after any refresh");

    refi_clear_a: assert property (
        is_ref && tim_ff[IX_REFI] > 10'h001 |=> !ref_req_o[$past(lr)])
        else $error("refresh request not dropped after refresh");

    req_block_a: assert property (
        ref_req_o[0] |-> act_ok_o[3:0] == 4'h0)
        else $error("activate permitted while refresh pending");

    viol_flag_a: assert property (
        is_act && !act_ok_o[ix] |=> viol_ff)
        else $error("violating activate not flagged");

    act_seen_c: cover property (is_act ##1 is_act);
    wtr_seen_c: cover property (wr_last_i ##[1:20] is_rd);
    req_seen_c: cover property (ref_req_o[0] ##[1:50] is_ref);

endmodule : dtc_checker

// ### design/dtc_pkg.sv
// Purpose: shared constants and types of the DDR4 command timing checker
// Assumes: memory clock of 100 MHz; the registers keep all intervals in clock cycles
// Notes:   times are held in their own unit and converted with round-up, except REFI, which rounds down

package dtc_pkg;

    // ----------------------------------------------------------------
    // geometry and widths
    // ----------------------------------------------------------------
    localparam int          LR_NUM     = 4;
    localparam int          BG_NUM     = 4;
    localparam int          CNT_W      = 10;
    localparam int          RA_W       = 4;
    localparam int          RD_W       = 16;
    localparam int          CLK_PS     = 10000;
    localparam logic [9:0]  CNT_MAX    = 10'h3FF;

    // ----------------------------------------------------------------
    // register indices on the plain register port
    // ----------------------------------------------------------------
    localparam logic [3:0]  IX_CFG     = 4'h0;
    localparam logic [3:0]  IX_RRD_S   = 4'h1;
    localparam logic [3:0]  IX_RRD_L   = 4'h2;
    localparam logic [3:0]  IX_RRD_DLR = 4'h3;
    localparam logic [3:0]  IX_FAW     = 4'h4;
    localparam logic [3:0]  IX_FAW_DLR = 4'h5;
    localparam logic [3:0]  IX_CCD_S   = 4'h6;
    localparam logic [3:0]  IX_CCD_L   = 4'h7;
    localparam logic [3:0]  IX_WTR_S   = 4'h8;
    localparam logic [3:0]  IX_WTR_L   = 4'h9;
    localparam logic [3:0]  IX_RFC     = 4'hA;
    localparam logic [3:0]  IX_RFC_DLR = 4'hB;
    localparam logic [3:0]  IX_REFI    = 4'hC;
    localparam logic [3:0]  IX_STATUS  = 4'hD;

    // config bits, status bits
    localparam int          CFG_3DS    = 0;
    localparam int          CFG_REFEN  = 1;
    localparam logic [15:0] CFG_RST    = 16'h0003;
    localparam int          ST_VIOL    = 0;
    localparam int          ST_REQ     = 4;

    // ----------------------------------------------------------------
    // interval defaults, each in its own unit
    // ----------------------------------------------------------------
    localparam int RRD_S_CYC   = 4;
    localparam int RRD_L_CYC   = 6;
    localparam int RRD_DLR_CYC = 4;
    localparam int FAW_NS      = 30;
    localparam int FAW_DLR_CYC = 16;
    localparam int CCD_S_CYC   = 4;
    localparam int CCD_L_CYC   = 6;
    localparam int WTR_S_CYC   = 3;
    localparam int WTR_L_CYC   = 9;
    localparam int RFC_NS      = 350;
    localparam int RFC_DLR_NS  = 120;
    localparam int REFI_NS     = 7800;

    // round a time in ns up to whole clock cycles, never below one
    function automatic logic [9:0] ns2cyc(input int ns);
        int c;
        c = (ns * 1000 + CLK_PS - 1) / CLK_PS;
        if (c < 1) begin
            c = 1;
        end
        return c[9:0];
    endfunction : ns2cyc

    localparam logic [9:0] FAW_RST     = ns2cyc(FAW_NS);
    localparam logic [9:0] RFC_RST     = ns2cyc(RFC_NS);
    localparam logic [9:0] RFC_DLR_RST = ns2cyc(RFC_DLR_NS);
    // average interval: a longest time, so it rounds down
    localparam logic [9:0] REFI_RST    = 10'((REFI_NS * 1000) / CLK_PS);

    // ----------------------------------------------------------------
    // command carrier
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        CK_ACT = 2'h0,
        CK_RD  = 2'h1,
        CK_WR  = 2'h2,
        CK_REF = 2'h3
    } dtc_kind_t;

    typedef struct packed {
        logic      vld;
        dtc_kind_t kind;
        logic [1:0] lr;
        logic [1:0] bg;
    } dtc_cmd_t;

endpackage : dtc_pkg

// ### testbench/dtc_dram_model.sv
// Purpose: far-side memory model that marks the end of write data
// Assumes: fixed write latency, one data end pulse per write command
// Notes:   WL sets how slowly the model answers a write

`timescale 1ns/1ns

module dtc_dram_model
    import dtc_pkg::*;
#(
    parameter int WL = 8
)(
    input  wire logic     clk_i,
    input  wire logic     reset_n_i,
    input  wire dtc_cmd_t cmd_i,
    output logic          wr_last_o,
    output logic [1:0]    wr_last_bg_o
);
    logic [WL-1:0] vld_ff;
    logic [1:0]    bg_ff [WL];
    logic [1:0]    last_ff;
    wire logic     wr_seen = cmd_i.vld && (cmd_i.kind == CK_WR);

    always_ff @(posedge clk_i) begin
        vld_ff   <= reset_n_i ? {vld_ff[WL-2:0], wr_seen} : '0;
        bg_ff[0] <= cmd_i.bg;
        for (int i = 1; i < WL; i++) begin
            bg_ff[i] <= bg_ff[i-1];
        end
        if (!reset_n_i) begin
            last_ff <= 2'h0;
        end else if (wr_last_o) begin
            last_ff <= bg_ff[WL-1];
        end
    end

    assign wr_last_o    = vld_ff[WL-1];
    // idle group line never repeats the last group, so stale use shows
    assign wr_last_bg_o = wr_last_o ? bg_ff[WL-1] : ~last_ff;
endmodule : dtc_dram_model

// ### testbench/dtc_checker_tb.sv
// Purpose: self-checking bench of the command timing checker
// Assumes: drivers act on rising edges, outputs sampled 1 ns later
// Notes:   expected values queue up as notes due in a given cycle

`timescale 1ns/1ns

`define CHK(g, e) begin checked++; if ((g) !== (e)) begin failures++; \
    $display("wrong value at %0t: %h expected %h", $time, g, e); end end

module dtc_checker_tb;
    import dtc_pkg::*;
    typedef struct {int due; int sel; logic [15:0] v;} dtc_note_t;
    logic        clk_i = 0, reset_n_i = 0, reg_wr = 0, reg_rd = 0;
    dtc_cmd_t    cmd = '0;
    logic [3:0]  addr = '0, rd_ok, wr_ok, ref_ok, ref_req;
    logic [15:0] wdata = '0, rdata, act_ok, got, m;
    logic        wr_last;
    logic [1:0]  wr_last_bg, g;
    logic [31:0] seed = 32'h0F255184;
    logic [15:0] dflt [13];
    int          failures = 0, checked = 0, cyc = 0, n;
    dtc_note_t   q [$];

    dtc_checker dtc_checker_i (.clk_i(clk_i), .reset_n_i(reset_n_i),
        .cmd_i(cmd), .wr_last_i(wr_last), .wr_last_bg_i(wr_last_bg),
        .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_wr_i(reg_wr),
        .reg_rd_i(reg_rd), .reg_rdata_o(rdata), .act_ok_o(act_ok),
        .rd_ok_o(rd_ok), .wr_ok_o(wr_ok), .ref_ok_o(ref_ok),
        .ref_req_o(ref_req));
    dtc_dram_model dtc_dram_model_i (.clk_i(clk_i), .reset_n_i(reset_n_i),
        .cmd_i(cmd), .wr_last_o(wr_last), .wr_last_bg_o(wr_last_bg));

    always #5 clk_i = ~clk_i;

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : rnd

    function automatic logic [15:0] up(input int ns);
        return 16'((ns * 1000 + CLK_PS - 1) / CLK_PS);
    endfunction : up

    task automatic drv(input dtc_cmd_t c, input logic w, r,
                       input logic [3:0] a, input logic [15:0] d);
        @(posedge clk_i);
        cmd    <= c;
        reg_wr <= w;
        reg_rd <= r;
        addr   <= a;
        wdata  <= d;
    endtask : drv

    task automatic idle(input int k);
        repeat (k) drv('0, 0, 0, 4'h0, 16'h0000);
    endtask : idle

    // a note falls due d cycles after the cycle just driven
    task automatic note(input int s, d, input logic [15:0] v);
        q.push_back('{cyc + 1 + d, s, v});
    endtask : note

    task automatic issue(input dtc_kind_t k, input int l, b);
        drv({1'b1, k, 2'(l), 2'(b)}, 0, 0, 4'h0, 16'h0000);
    endtask : issue

    task automatic wreg(input logic [3:0] a, input logic [15:0] d);
        drv('0, 1, 0, a, d);
    endtask : wreg

    task automatic rreg(input logic [3:0] a, input logic [15:0] v);
        drv('0, 0, 1, a, 16'h0000);
        note(0, 1, v);
    endtask : rreg

    task automatic act4(input logic by_rank);
        for (int i = 0; i < 4; i++) begin
            issue(CK_ACT, by_rank ? i : 0, by_rank ? 0 : i);
            if (i < 3) idle(3);
        end
    endtask : act4

    task automatic test_done();
        $display("checked %0d failures %0d", checked, failures);
        if (failures == 0 && checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : test_done

    always @(posedge clk_i) begin
        #1;
        cyc++;
        while (q.size() > 0 && q[0].due <= cyc) begin
            case (q[0].sel)
                0: got = rdata;
                1: got = act_ok;
                2: got = 16'(rd_ok);
                3: got = 16'(wr_ok);
                4: got = 16'(ref_ok);
                default: got = 16'(ref_req);
            endcase
            `CHK(got, q[0].v)
            void'(q.pop_front());
        end
    end

    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial begin
        dflt = '{CFG_RST, 16'(RRD_S_CYC), 16'(RRD_L_CYC), 16'(RRD_DLR_CYC),
                 up(FAW_NS), 16'(FAW_DLR_CYC), 16'(CCD_S_CYC), 16'(CCD_L_CYC),
                 16'(WTR_S_CYC), 16'(WTR_L_CYC), up(RFC_NS), up(RFC_DLR_NS),
                 16'((REFI_NS * 1000) / CLK_PS)};
        repeat (10) @(posedge clk_i);
        reset_n_i <= 1'b1;
        for (n = 0; n < 13; n++) rreg(4'(n), dflt[n]);
        rreg(4'hE, 16'h0000);
        m = 16'(rnd());
        wreg(IX_RRD_DLR, m);
        rreg(IX_RRD_DLR, m & 16'h03FF);
        wreg(IX_RRD_DLR, dflt[3]);
        wreg(IX_CFG, 16'h0001);
        $display("registers done");
        g = 2'(rnd());
        m = 16'hFFFF ^ (16'h0001 << g);
        idle(8);
        issue(CK_ACT, 0, g);
        note(1, 1, 16'h0000);
        note(1, 3, 16'h0000);
        note(1, 4, m);
        note(1, 5, m);
        note(1, 6, 16'hFFFF);
        idle(8);
        issue(CK_ACT, 0, 0);
        issue(CK_ACT, 0, 0);
        idle(1);
        rreg(IX_STATUS, 16'h0001);
        wreg(IX_STATUS, 16'h0001);
        rreg(IX_STATUS, 16'h0000);
        wreg(IX_FAW, 16'h0014);
        idle(8);
        act4(0);
        note(1, 4, 16'hFFF0);
        note(1, 8, 16'hFFFF);
        idle(12);
        wreg(IX_FAW_DLR, 16'h0014);
        idle(8);
        act4(1);
        note(1, 4, 16'h0000);
        note(1, 8, 16'hFFFF);
        idle(12);
        for (n = 1; n < 13; n++) wreg(4'(n), dflt[n]);
        $display("activate spacing done");
        g = 2'(rnd());
        m = 16'h000F ^ (16'h0001 << g);
        issue(CK_RD, 0, g);
        note(2, 1, 16'h0000);
        note(3, 1, 16'h0000);
        note(2, 4, m);
        note(3, 4, m);
        note(2, 6, 16'h000F);
        note(3, 6, 16'h000F);
        idle(10);
        issue(CK_WR, 0, g);
        note(2, 8, 16'h000F);
        note(2, 9, 16'h0000);
        note(2, 10, 16'h0000);
        note(2, 11, m);
        note(2, 16, m);
        note(2, 17, 16'h000F);
        idle(16);
        issue(CK_RD, 0, g);
        rreg(IX_STATUS, 16'h0000);
        idle(3);
        $display("column spacing done");
        wreg(IX_RFC, 16'h0010);
        wreg(IX_REFI, 16'h0014);
        wreg(IX_CFG, 16'h0003);
        for (n = 0; n < 100; n++) begin
            idle(1);
            #2;
            if (ref_req === 4'hF) break;
        end
        if (n == 100) begin
            failures++;
            test_done();
        end
        issue(CK_REF, 0, 0);
        note(1, 0, 16'h0000);
        note(5, 1, 16'h000E);
        note(5, 4, 16'h0000);
        note(1, 15, 16'h0000);
        note(1, 16, 16'h000F);
        note(1, 19, 16'hFFFF);
        for (n = 1; n < 4; n++) issue(CK_REF, n, 0);
        wreg(IX_REFI, 16'h03FF);
        idle(20);
        wreg(IX_RFC, 16'h0004);
        idle(20);
        issue(CK_REF, 0, 0);
        note(4, 1, 16'h000E);
        note(1, 3, 16'h0000);
        note(4, 4, 16'h000F);
        note(1, 4, 16'h000F);
        note(1, 12, 16'hFFFF);
        idle(16);
        $display("refresh done");
        test_done();
    end
endmodule : dtc_checker_tb
